// file: kbcond_top.sv
// Keyboard key conditioning: delayed keys, cursor stepping with repeat, view/hold timer
`timescale 1ns/1ps
`default_nettype none
module kbcond_top
   import kbcond_pkg::*;
#(
   parameter int unsigned KEY_HOLD     = 32'(KEY_HOLD_CYC),
   parameter int unsigned FIRST_STEP   = 32'(FIRST_STEP_CYC),
   parameter int unsigned REPEAT_DELAY = 32'(REPEAT_DELAY_CYC),
   parameter int unsigned REPEAT_TICK  = 32'(REPEAT_TICK_CYC),
   parameter int unsigned VIEW_PERIOD  = 32'(VIEW_CYC),
   parameter int unsigned BLINK_HALF   = 32'(BLINK_HALF_CYC),
   parameter bit          CHECK_RANGE  = 1'b1
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst,
   // Delayed keys, active low
   input  wire logic i_margin_shift_button_n,
   input  wire logic i_edit_key_in_n,
   input  wire logic i_full_duplex_key_in_n,
   input  wire logic i_send_key_in_n,
   input  wire logic i_break_key_in_n,
   // Cursor keys, active low
   input  wire logic i_left_arrow_key_in_n,
   input  wire logic i_right_arrow_key_in_n,
   input  wire logic i_down_arrow_key_in_n,
   input  wire logic i_up_arrow_key_in_n,
   // View control, same clock domain
   input  wire logic i_view_restart,
   input  wire logic i_compose_mode,
   // Delayed key outputs, active low
   output logic      o_margin_shift_button_n,
   output logic      o_edit_key_in_n,
   output logic      o_full_duplex_key_in_n,
   output logic      o_send_key_in_n,
   output logic      o_break_key_in_n,
   // Cursor outputs
   output logic      o_x_step_pulse_n,
   output logic      o_y_step_pulse_n,
   output logic      o_leftward_flag,
   output logic      o_upward_flag,
   // View/hold outputs
   output logic      o_hold_n,
   output logic      o_view,
   output logic      o_viewing_lamp
);
   localparam int unsigned PULSE_CYC = 32'(STEP_PULSE_CYC);

   // A repeat fire inside a running step pulse would merge two steps into one
   if (FIRST_STEP < 1 || REPEAT_DELAY <= FIRST_STEP + PULSE_CYC || REPEAT_TICK <= PULSE_CYC || BLINK_HALF < 1) begin
      $error("Cursor or blink timing parameters out of range");
   end
   if (CHECK_RANGE && (longint'(VIEW_PERIOD) < VIEW_MIN_CYC || longint'(VIEW_PERIOD) > VIEW_MAX_CYC)) begin
      $error("VIEW_PERIOD outside the 60 to 120 s window");
   end

   // Delayed keys
   logic [N_DLY-1:0] dly_in_n;
   logic [N_DLY-1:0] dly_out_n;
   logic [N_CUR-1:0] cur_in_n;
   logic [N_CUR-1:0] cur_sync_n;
   logic [N_CUR-1:0] held;

   assign dly_in_n = {i_break_key_in_n, i_send_key_in_n, i_full_duplex_key_in_n,
                      i_edit_key_in_n, i_margin_shift_button_n};
   assign cur_in_n = {i_up_arrow_key_in_n, i_down_arrow_key_in_n,
                      i_right_arrow_key_in_n, i_left_arrow_key_in_n};

   genvar g;
   generate
      for (g = 0; g < N_DLY; g++) begin : g_dly
         kbcond_key_stretch #(.HOLD_CYC(KEY_HOLD)) u_dly (
            .i_clk       (i_clk),
            .i_rst       (i_rst),
            .i_key_n     (dly_in_n[g]),
            .o_sync_n    (),
            .o_stretch_n (dly_out_n[g])
         );
      end
      for (g = 0; g < N_CUR; g++) begin : g_cur
         kbcond_key_stretch #(.HOLD_CYC(1)) u_cur (
            .i_clk       (i_clk),
            .i_rst       (i_rst),
            .i_key_n     (cur_in_n[g]),
            .o_sync_n    (cur_sync_n[g]),
            .o_stretch_n ()
         );
      end
   endgenerate

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_margin_shift_button_n <= 1'b1;
         o_edit_key_in_n         <= 1'b1;
         o_full_duplex_key_in_n  <= 1'b1;
         o_send_key_in_n         <= 1'b1;
         o_break_key_in_n        <= 1'b1;
      end else begin
         o_margin_shift_button_n <= dly_out_n[0];
         o_edit_key_in_n         <= dly_out_n[1];
         o_full_duplex_key_in_n  <= dly_out_n[2];
         o_send_key_in_n         <= dly_out_n[3];
         o_break_key_in_n        <= dly_out_n[4];
      end
   end

   // Cursor press detection and timers
   logic             any_held;
   logic             any_held_d_r;
   logic             press;
   logic [N_CUR-1:0] latch_r;
   logic             first_run_r;
   logic [31:0]      first_cnt_r;
   logic             rep_wait_r;
   logic [31:0]      rep_cnt_r;
   logic             rep_arm_r;
   logic [31:0]      tick_cnt_r;
   logic             tick;
   logic             fire;
   logic [N_CUR-1:0] fire_dir;
   logic [31:0]      pulse_cnt_r;

   assign held     = ~cur_sync_n;
   assign any_held = |held;
   assign press    = any_held & ~any_held_d_r;
   assign tick     = (tick_cnt_r == 32'h0000_0000);

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tick_cnt_r <= 32'h0000_0000;
      end else if (tick) begin
         tick_cnt_r <= REPEAT_TICK - 32'h0000_0001;
      end else begin
         tick_cnt_r <= tick_cnt_r - 32'h0000_0001;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         any_held_d_r <= 1'b0;
         latch_r      <= '0;
         first_run_r  <= 1'b0;
         first_cnt_r  <= 32'h0000_0000;
      end else begin
         any_held_d_r <= any_held;
         if (press) begin
            latch_r     <= held;
            first_run_r <= 1'b1;
            first_cnt_r <= FIRST_STEP - 32'h0000_0001;
         end else if (first_run_r) begin
            if (first_cnt_r == 32'h0000_0000)
               first_run_r <= 1'b0;
            else
               first_cnt_r <= first_cnt_r - 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rep_wait_r <= 1'b0;
         rep_cnt_r  <= 32'h0000_0000;
         rep_arm_r  <= 1'b0;
      end else if (press) begin
         rep_wait_r <= 1'b1;
         rep_cnt_r  <= REPEAT_DELAY - 32'h0000_0001;
         rep_arm_r  <= 1'b0;
      end else if (!any_held) begin
         rep_wait_r <= 1'b0;
         rep_arm_r  <= 1'b0;
      end else if (rep_wait_r) begin
         if (rep_cnt_r == 32'h0000_0000) begin
            rep_wait_r <= 1'b0;
            rep_arm_r  <= 1'b1;
         end else begin
            rep_cnt_r <= rep_cnt_r - 32'h0000_0001;
         end
      end
   end

   // First step uses the latched key; repeats need the key still held
   always_comb begin
      fire     = 1'b0;
      fire_dir = '0;
      if (first_run_r && first_cnt_r == 32'h0000_0000) begin
         fire     = 1'b1;
         fire_dir = latch_r;
      end else if (rep_arm_r && tick && |(held & latch_r)) begin
         fire     = 1'b1;
         fire_dir = held & latch_r;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pulse_cnt_r      <= 32'h0000_0000;
         o_x_step_pulse_n <= 1'b1;
         o_y_step_pulse_n <= 1'b1;
         o_leftward_flag  <= 1'b0;
         o_upward_flag    <= 1'b0;
      end else if (fire) begin
         pulse_cnt_r      <= PULSE_CYC - 32'h0000_0001;
         o_x_step_pulse_n <= ~(fire_dir[CUR_LEFT] | fire_dir[CUR_RIGHT]);
         o_y_step_pulse_n <= ~(fire_dir[CUR_DOWN] | fire_dir[UPWARD_FLAG]);
         o_leftward_flag  <= fire_dir[CUR_LEFT];
         o_upward_flag    <= fire_dir[UPWARD_FLAG];
      end else if (pulse_cnt_r != 32'h0000_0000) begin
         pulse_cnt_r <= pulse_cnt_r - 32'h0000_0001;
      end else begin
         o_x_step_pulse_n <= 1'b1;
         o_y_step_pulse_n <= 1'b1;
         o_leftward_flag  <= 1'b0;
         o_upward_flag    <= 1'b0;
      end
   end

   // View/hold timer
   kbcond_view_t view_st_r;
   logic [31:0]  view_cnt_r;
   logic [31:0]  blink_cnt_r;
   logic [3:0]   blink_half_r;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         view_st_r    <= VW_VIEW;
         view_cnt_r   <= VIEW_PERIOD;
         blink_cnt_r  <= 32'h0000_0000;
         blink_half_r <= 4'h0;
      end else if (i_view_restart || i_compose_mode) begin
         view_st_r    <= VW_VIEW;
         view_cnt_r   <= VIEW_PERIOD;
         blink_half_r <= 4'h0;
      end else begin
         case (view_st_r)
            VW_VIEW: begin
               if (view_cnt_r <= 32'h0000_0001) begin
                  view_st_r    <= VW_WARN;
                  blink_cnt_r  <= BLINK_HALF - 32'h0000_0001;
                  blink_half_r <= 4'h0;
               end else begin
                  view_cnt_r <= view_cnt_r - 32'h0000_0001;
               end
            end
            VW_WARN: begin
               if (blink_cnt_r != 32'h0000_0000) begin
                  blink_cnt_r <= blink_cnt_r - 32'h0000_0001;
               end else if (blink_half_r == 4'(2 * WARN_BLINKS - 1)) begin
                  view_st_r <= VW_HOLD;
               end else begin
                  blink_half_r <= blink_half_r + 4'h1;
                  blink_cnt_r  <= BLINK_HALF - 32'h0000_0001;
               end
            end
            VW_HOLD: view_st_r <= VW_HOLD;
            default: view_st_r <= VW_VIEW;
         endcase
      end
   end

   // Lamp goes dark on even half periods of the warning
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_hold_n       <= 1'b1;
         o_view         <= 1'b1;
         o_viewing_lamp <= 1'b1;
      end else begin
         o_hold_n       <= (view_st_r != VW_HOLD);
         o_view         <= (view_st_r != VW_HOLD);
         o_viewing_lamp <= (view_st_r == VW_VIEW) ||
                           (view_st_r == VW_WARN && blink_half_r[0]);
      end
   end
endmodule
`default_nettype wire

// file: kbcond_pkg.sv
// Shared timing constants and index codes for the keyboard key-conditioning block
package kbcond_pkg;
   localparam longint CLK_HZ          = 64'd25_000_000;
   localparam longint CLK_PERIOD_NS   = 64'd40;
   localparam longint KEY_HOLD_MS     = 64'd10;
   localparam longint FIRST_STEP_MS   = 64'd10;
   localparam longint REPEAT_DELAY_MS = 64'd330;
   localparam longint REPEAT_HZ       = 64'd20;
   localparam longint STEP_PULSE_NS   = 64'd2500;
   localparam longint VIEW_MIN_S      = 64'd60;
   localparam longint VIEW_MAX_S      = 64'd120;
   localparam longint VIEW_S          = 64'd90;
   localparam longint BLINK_HALF_MS   = 64'd250;
   localparam int     WARN_BLINKS     = 7;

   // Least times round up, periods round down
   localparam longint KEY_HOLD_CYC     = (KEY_HOLD_MS * CLK_HZ + 64'd999) / 64'd1000;
   localparam longint FIRST_STEP_CYC   = (FIRST_STEP_MS * CLK_HZ) / 64'd1000;
   localparam longint REPEAT_DELAY_CYC = (REPEAT_DELAY_MS * CLK_HZ) / 64'd1000;
   localparam longint REPEAT_TICK_CYC  = CLK_HZ / REPEAT_HZ;
   localparam longint STEP_PULSE_CYC   = (STEP_PULSE_NS + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;
   localparam longint VIEW_CYC         = VIEW_S * CLK_HZ;
   localparam longint VIEW_MIN_CYC     = VIEW_MIN_S * CLK_HZ;
   localparam longint VIEW_MAX_CYC     = VIEW_MAX_S * CLK_HZ;
   localparam longint BLINK_HALF_CYC   = (BLINK_HALF_MS * CLK_HZ) / 64'd1000;

   // Cursor key index
   localparam int CUR_LEFT  = 0;
   localparam int CUR_RIGHT = 1;
   localparam int CUR_DOWN  = 2;
   localparam int UPWARD_FLAG    = 3;
   localparam int N_CUR     = 4;
   localparam int N_DLY     = 5;

   typedef enum logic [1:0] {
      VW_VIEW,
      VW_WARN,
      VW_HOLD
   } kbcond_view_t;
endpackage

// file: kbcond_key_stretch.sv
// Key input synchroniser with release-delay stretcher
`timescale 1ns/1ps
`default_nettype none
module kbcond_key_stretch #(
   parameter int unsigned HOLD_CYC = 250000
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst,
   // Key line, active low, asynchronous
   input  wire logic i_key_n,
   // Conditioned outputs
   output logic      o_sync_n,
   output logic      o_stretch_n
);
   localparam int CW = $clog2(HOLD_CYC + 1);

   if (HOLD_CYC < 1) begin
      $error("HOLD_CYC must be at least 1");
   end

   logic          meta_r;
   logic [CW-1:0] cnt_r;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_r   <= 1'b1;
         o_sync_n <= 1'b1;
      end else begin
         meta_r   <= i_key_n;
         o_sync_n <= meta_r;
      end
   end

   // Low while pressed, then low for HOLD_CYC more cycles
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_r       <= '0;
         o_stretch_n <= 1'b1;
      end else if (!o_sync_n) begin
         cnt_r       <= CW'(HOLD_CYC);
         o_stretch_n <= 1'b0;
      end else if (cnt_r > CW'(1)) begin
         cnt_r <= cnt_r - CW'(1);
      end else begin
         cnt_r       <= '0;
         o_stretch_n <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: kbcond_props.sv
// Port-level assertions for the keyboard key-conditioning top
`timescale 1ns/1ps
`default_nettype none
module kbcond_props (
   // Watched top-level ports
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_edit_key_in_n,
   input wire logic i_view_restart,
   input wire logic i_compose_mode,
   input wire logic o_edit_key_in_n,
   input wire logic o_x_step_pulse_n,
   input wire logic o_y_step_pulse_n,
   input wire logic o_leftward_flag,
   input wire logic o_upward_flag,
   input wire logic o_hold_n,
   input wire logic o_view,
   input wire logic o_viewing_lamp
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   logic [7:0] xl_r;
   logic [7:0] yl_r;
   // Length of the current low phase of each step line
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         xl_r <= 8'h00;
         yl_r <= 8'h00;
      end else begin
         xl_r <= o_x_step_pulse_n ? 8'h00 : xl_r + 8'h01;
         yl_r <= o_y_step_pulse_n ? 8'h00 : yl_r + 8'h01;
      end
   end
   property p_x_width; $rose(o_x_step_pulse_n) |-> xl_r == 8'h3F; endproperty
   a_x_width: assert property (p_x_width) else $error("x step width wrong");
   property p_y_width; $rose(o_y_step_pulse_n) |-> yl_r == 8'h3F; endproperty
   a_y_width: assert property (p_y_width) else $error("y step width wrong");
   property p_left; o_leftward_flag |-> !o_x_step_pulse_n; endproperty
   a_left: assert property (p_left) else $error("left flag outside x pulse");
   property p_up; o_upward_flag |-> !o_y_step_pulse_n; endproperty
   a_up: assert property (p_up) else $error("up flag outside y pulse");
   property p_edit_on; $fell(i_edit_key_in_n) |-> ##[1:5] !o_edit_key_in_n; endproperty
   a_edit_on: assert property (p_edit_on) else $error("edit output not low");
   property p_edit_tail; $rose(i_edit_key_in_n) |-> !o_edit_key_in_n [*8]; endproperty
   a_edit_tail: assert property (p_edit_tail) else $error("edit tail too short");
   property p_edit_off; $rose(i_edit_key_in_n) |-> ##[16:30] o_edit_key_in_n; endproperty
   a_edit_off: assert property (p_edit_off) else $error("edit tail too long");
   property p_hold_lamp; !o_hold_n |-> !o_viewing_lamp && !o_view; endproperty
   a_hold_lamp: assert property (p_hold_lamp) else $error("lamp or view on in hold");
   property p_compose; i_compose_mode [*3] |-> o_hold_n && o_viewing_lamp; endproperty
   a_compose: assert property (p_compose) else $error("timer ran in compose");
   property p_restart; i_view_restart |-> ##[1:2] (o_hold_n && o_view); endproperty
   a_restart: assert property (p_restart) else $error("restart did not clear hold");
endmodule
bind kbcond_top kbcond_props u_props (.*);
`default_nettype wire

// file: kbcond_kbd_model.sv
// Key switch bank: nine active-low lines with pull-ups
`timescale 1ns/1ps
`default_nettype none
module kbcond_kbd_model (
   // Clock and key lines
   input  wire logic i_clk,
   output logic [8:0] o_key_n
);
   initial o_key_n = 9'h1FF;
   // Hold one switch closed for a number of cycles
   task automatic tap(input int idx, input int cyc);
      @(posedge i_clk) o_key_n[idx] <= 1'b0;
      repeat (cyc) @(posedge i_clk);
      o_key_n[idx] <= 1'b1;
   endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the keyboard key-conditioning block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // Repeat delay must exceed first step plus the 63-cycle step pulse, and tick the pulse alone, so steps stay apart
   localparam int KH = 20, FS = 10, RD = 100, RT = 80, VP = 50, BH = 4;
   logic i_clk = 1'b0, i_rst = 1'b1, restart = 1'b0, compose = 1'b0;
   logic [8:0] key_n;
   logic [4:0] dly_n;
   logic x_n, y_n, lf, uf, hold_n, view, lamp;
   logic [4:0] prv = 5'h13;
   int n_fail = 0, samples_checked = 0, cyc = 0;
   int nx = 0, ny = 0, nl = 0, nu = 0, nlamp = 0;
   always #20 i_clk = ~i_clk;
   kbcond_kbd_model kbd (.i_clk(i_clk), .o_key_n(key_n));
   kbcond_top #(.KEY_HOLD(KH), .FIRST_STEP(FS), .REPEAT_DELAY(RD), .REPEAT_TICK(RT),
      .VIEW_PERIOD(VP), .BLINK_HALF(BH), .CHECK_RANGE(1'b0)) dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_margin_shift_button_n(key_n[0]), .i_edit_key_in_n(key_n[1]),
      .i_full_duplex_key_in_n(key_n[2]), .i_send_key_in_n(key_n[3]), .i_break_key_in_n(key_n[4]),
      .i_left_arrow_key_in_n(key_n[5]), .i_right_arrow_key_in_n(key_n[6]),
      .i_down_arrow_key_in_n(key_n[7]), .i_up_arrow_key_in_n(key_n[8]),
      .i_view_restart(restart), .i_compose_mode(compose),
      .o_margin_shift_button_n(dly_n[0]), .o_edit_key_in_n(dly_n[1]), .o_full_duplex_key_in_n(dly_n[2]),
      .o_send_key_in_n(dly_n[3]), .o_break_key_in_n(dly_n[4]), .o_x_step_pulse_n(x_n),
      .o_y_step_pulse_n(y_n), .o_leftward_flag(lf), .o_upward_flag(uf),
      .o_hold_n(hold_n), .o_view(view), .o_viewing_lamp(lamp));
   task automatic finish_test();
      if (n_fail == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic kick();
      @(posedge i_clk) restart <= 1'b1;
      @(posedge i_clk) restart <= 1'b0;
      #1;
   endtask
   // Edge counters on the step, flag and lamp lines, plus the hang limit
   always @(posedge i_clk) begin
      prv <= {lamp, uf, lf, y_n, x_n};
      if (prv[0] && !x_n) nx++;
      if (prv[1] && !y_n) ny++;
      if (!prv[2] && lf) nl++;
      if (!prv[3] && uf) nu++;
      if (!prv[4] && lamp) nlamp++;
      cyc++;
      if (cyc > 5000) begin
         n_fail++;
         finish_test();
      end
   end
   task automatic t_delayed();
      for (int k = 0; k < 5; k++) begin
         kbd.tap(k, 6);
         wt(2);
         chk({3'h0, dly_n}, 8'h1F ^ (8'h01 << k));
         wt(KH - 6);
         chk({3'h0, dly_n}, 8'h1F ^ (8'h01 << k));
         wt(14);
         chk({3'h0, dly_n}, 8'h1F);
      end
   endtask
   task automatic t_brief();
      int x0, y0, l0, u0;
      for (int k = 0; k < 4; k++) begin
         x0 = nx;
         y0 = ny;
         l0 = nl;
         u0 = nu;
         kbd.tap(5 + k, 3);
         wt(150);
         chk(8'(nx - x0), 8'(k < 2));
         chk(8'(ny - y0), 8'(k >= 2));
         chk(8'(nl - l0), 8'(k == 0));
         chk(8'(nu - u0), 8'(k == 3));
      end
   endtask
   task automatic t_repeat();
      int x0, y0, t0;
      x0 = nx;
      y0 = ny;
      t0 = cyc;
      fork
         kbd.tap(6, 200);
      join_none
      for (int i = 0; i < 30 && nx == x0; i++) wt(1);
      chk(8'(cyc - t0 >= FS && cyc - t0 <= FS + 7), 8'h01);
      wt(t0 + RD - cyc);
      chk(8'(nx - x0), 8'h01);
      wt(t0 + 212 - cyc);
      chk(8'(nx - x0 >= 2), 8'h01);
      chk(8'(ny - y0), 8'h00);
      x0 = nx;
      wt(100);
      chk(8'(nx - x0), 8'h00);
   endtask
   task automatic t_view();
      int l0;
      kick();
      wt(VP - 10);
      chk({5'h00, hold_n, view, lamp}, 8'h07);
      l0 = nlamp;
      wt(14 * BH + 20);
      chk({5'h00, hold_n, view, lamp}, 8'h00);
      chk(8'(nlamp - l0), 8'h07);
      kick();
      wt(1);
      chk({5'h00, hold_n, view, lamp}, 8'h07);
      wt(VP + 10);
      kick();
      wt(VP + 20);
      chk({7'h00, hold_n}, 8'h01);
      @(posedge i_clk) compose <= 1'b1;
      wt(200);
      chk({7'h00, hold_n}, 8'h01);
      @(posedge i_clk) compose <= 1'b0;
      wt(VP + 14 * BH + 20);
      chk({7'h00, hold_n}, 8'h00);
   endtask
   initial begin
      repeat (6) @(posedge i_clk);
      i_rst <= 1'b0;
      wt(2);
      chk({1'b0, x_n, y_n, lf, uf, hold_n, view, lamp}, 8'h67);
      chk({3'h0, dly_n}, 8'h1F);
      t_delayed();
      t_brief();
      t_repeat();
      t_view();
      finish_test();
   end
endmodule
`default_nettype wire
